// >>> rtl/ccsg_pkg.sv
/*
  Package for the clock synthesizer and gating block: register indices,
  field positions and reset values.
  Assumes an indexed sequencer port with 8-bit index and 8-bit data.
*/
package ccsg_pkg;
  localparam logic [7:0] IDX_UNLOCK = 8'h08;
  localparam logic [7:0] IDX_CTRL1_GATE = 8'h09;
  localparam logic [7:0] IDX_MEM_LO = 8'h10;
  localparam logic [7:0] IDX_MEM_HI = 8'h11;
  localparam logic [7:0] IDX_PIX_LO = 8'h12;
  localparam logic [7:0] IDX_PIX_HI = 8'h13;
  localparam logic [7:0] IDX_SYN1 = 8'h14;
  localparam logic [7:0] IDX_SYN2 = 8'h15;
  localparam logic [7:0] IDX_TEST_A = 8'h16;
  localparam logic [7:0] IDX_TEST_B = 8'h17;
  localparam logic [7:0] IDX_CONV = 8'h18;
  localparam logic [7:0] IDX_ENC_BUS = 8'h1c;
  localparam logic [7:0] IDX_STREAMS = 8'h1d;
  localparam logic [7:0] IDX_CTRL = 8'h1e;
  localparam logic [7:0] IDX_MEMBR = 8'h1f;
  localparam logic [7:0] IDX_LOOP = 8'h20;
  localparam logic [7:0] IDX_CTAB = 8'h21;
  localparam logic [7:0] IDX_SET0_LO = 8'h22;
  localparam logic [7:0] IDX_SET0_HI = 8'h23;
  localparam logic [7:0] IDX_SET1_LO = 8'h24;
  localparam logic [7:0] IDX_SET1_HI = 8'h25;
  localparam logic [7:0] IDX_MEM_SEL = 8'h27;
  localparam logic [7:0] IDX_PIX_SEL = 8'h28;
  localparam logic [7:0] IDX_LOCK_FIRST = 8'h09;
  localparam logic [7:0] IDX_LOCK_LAST = 8'h1c;
  localparam logic [3:0] UNLOCK_KEY = 4'h6;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Synth and converter control bits
  localparam int SYN1_PIX_PD = 0;
  localparam int SYN1_MEM_PD = 1;
  localparam int SYN1_CLR_CNT = 4;
  localparam int SYN2_LOAD_MEM = 0;
  localparam int SYN2_LOAD_PIX = 1;
  localparam int SYN2_LOAD_NOW = 5;
  localparam int SYN2_TWO_CYC_WR = 7;
  localparam int CONV_ONE_CYC = 6;
  localparam int CONV_DOUBLE = 7;
  // Power control bits
  localparam int LOOP_PIX_OFF_SUSP = 3;
  localparam int LOOP_MEM_OFF_SUSP = 4;
  localparam int LOOP_PADS_SUSP = 7;
  localparam int MEMBR_ENABLE = 5;
  localparam logic [1:0] MODE_VIRT_OFF = 2'b11;
endpackage

// >>> rtl/ccsg_top.sv
/*
  Clock synthesizer register file and branch clock gating.
  Assumes: clk is the gated source domain, power state inputs and unit
  disable inputs are synchronous to clk, registers reached through the
  sequencer index/data port, branch enables drive glitch-free gate cells.
*/
// Functional notes
// - Memory synth takes N bits 4-0, R bits 6-5 low, M bits 6-0 high.
// - Pixel synth takes N bits 5-0, R bits 7-6 low, M bits 7-0 high.
// - Two extra pixel parameter sets each hold N, R and M.
// - Control two bits 0,1 load memory, pixel values; bit 5 loads both now.
// - Control two bit 7 makes memory writes take two memory cycles.
// - Control one bit 0 powers down pixel loop, bit 1 memory loop.
// - Control one bit 4 clears the synthesizer counters.
// - Encoder clock stops when disabled, Standby or Suspend per bits 2-4.
// - Local bus clock stops when disabled, Standby or Suspend per bits 5-7.
// - Streams branch 1 stops per bits 3-5, branch 2 per bits 6-7.
// - Controller clocks stop when disabled; controller 2 also in Standby, not Suspend.
// - Bus interface system clock stops in Suspend when bit 7 set.
// - Memory clock branches stop in Suspend under their own bits.
// - Memory gating bit 5 enables memory clock stop in Suspend.
// - Loop power control bits 3 and 4 power off loops in Suspend.
// - Power bit 7 puts pads in suspend configuration in Suspend.
// - Color tables disabled or powered down per their own bits.
// - Controller 1 true and virtual clocks stop in Standby and Suspend.
// - Controller 1 virtual clock stops when display mode field is 11.
// - Converter control bit 7 selects clock-doubled converter mode.
// - Converter control bit 6 selects one-cycle lookup table writes.
`timescale 1ns/1ps
`default_nettype none
module ccsg_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Sequencer register port
  input wire logic [7:0] seq_index,
  input wire logic seq_wr,
  input wire logic seq_rd,
  input wire logic [7:0] seq_wdata,
  output logic [7:0] seq_rdata,
  // Power state and unit status
  input wire logic in_standby,
  input wire logic in_suspend,
  input wire logic encoder_disabled,
  input wire logic local_bus_disabled,
  input wire logic streams_disabled,
  input wire logic ctrl1_disabled,
  input wire logic ctrl2_disabled,
  input wire logic [1:0] display_mode,
  // Memory synthesizer
  output logic [4:0] mem_n,
  output logic [1:0] mem_r,
  output logic [6:0] mem_m,
  output logic mem_load,
  output logic mem_loop_pd,
  output logic [1:0] mem_src_sel,
  output logic [1:0] mem_div_sel,
  // Pixel synthesizer
  output logic [5:0] pix_n,
  output logic [1:0] pix_r,
  output logic [7:0] pix_m,
  output logic [5:0] pix_set0_n,
  output logic [1:0] pix_set0_r,
  output logic [7:0] pix_set0_m,
  output logic [5:0] pix_set1_n,
  output logic [1:0] pix_set1_r,
  output logic [7:0] pix_set1_m,
  output logic pix_load,
  output logic pix_loop_pd,
  output logic [1:0] pix_src_a_sel,
  output logic [1:0] pix_div_a_sel,
  output logic [1:0] pix_src_b_sel,
  output logic [1:0] pix_div_b_sel,
  output logic synth_cnt_clear,
  // Modes
  output logic mem_two_cycle_write,
  output logic conv_clock_double,
  output logic color_lookup_table_one_cycle_write,
  output logic pads_suspend,
  // Branch clock enables, high lets the clock run; color table enables, high powers the table on
  output logic encoder_clk_en,
  output logic local_bus_clk_en,
  output logic streams_clk1_en,
  output logic streams_clk2_en,
  output logic ctrl1_true_clk_en,
  output logic ctrl1_virt_clk_en,
  output logic ctrl2_clk_en,
  output logic biu_sys_clk_en,
  output logic ge_mclk_en,
  output logic dm_mclk_en,
  output logic biu_mclk_en,
  output logic lpb_mclk_en,
  output logic disp_mclk_en,
  output logic fp_mclk_en,
  output logic mclk_en,
  output logic ctab1_on,
  output logic ctab2_on
);
  logic [7:0] regs_q [8'h08:8'h28];
  logic unlocked;
  logic wr_ok;
  logic [7:0] w_enc, w_sp, w_ct, w_mb, w_lp, w_tb, w_s1, w_s2, w_c1;
  logic g_enc, g_lb, g_s1, g_s2, g_t1, g_v1, g_c2, g_biu;
  logic g_ge, g_dm, g_bm, g_lm, g_dp, g_fp, g_mc, g_k1, g_k2;

  function automatic logic mapped(input logic [7:0] idx);
    if (idx == ccsg_pkg::IDX_UNLOCK) mapped = 1'b1;
    else if (idx == ccsg_pkg::IDX_CTRL1_GATE) mapped = 1'b1;
    else if (idx >= ccsg_pkg::IDX_MEM_LO && idx <= ccsg_pkg::IDX_CONV) mapped = 1'b1;
    else if (idx >= ccsg_pkg::IDX_ENC_BUS && idx <= ccsg_pkg::IDX_SET1_HI) mapped = 1'b1;
    else if (idx == ccsg_pkg::IDX_MEM_SEL || idx == ccsg_pkg::IDX_PIX_SEL) mapped = 1'b1;
    else mapped = 1'b0;
  endfunction

  // Stop term: enable bit for a condition, and the condition present
  function automatic logic stop3(input logic [2:0] bits, input logic c0, input logic c1, input logic c2);
    stop3 = (bits[0] & c0) | (bits[1] & c1) | (bits[2] & c2);
  endfunction

  assign unlocked = (regs_q[ccsg_pkg::IDX_UNLOCK][3:0] == ccsg_pkg::UNLOCK_KEY);
  // Locked range ignores writes until the key is present
  assign wr_ok = mapped(seq_index) &&
    (unlocked || seq_index < ccsg_pkg::IDX_LOCK_FIRST || seq_index > ccsg_pkg::IDX_LOCK_LAST);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 8'h08; i <= 8'h28; i++)
      begin
        regs_q[i] <= ccsg_pkg::REG_RESET;
      end
    end
    else if (clk_en && seq_wr && wr_ok)
    begin
      regs_q[seq_index] <= seq_wdata;
    end
  end

  // Unmapped indices read as zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      seq_rdata <= 8'h00;
    end
    else if (clk_en && seq_rd)
    begin
      seq_rdata <= mapped(seq_index) ? regs_q[seq_index] : 8'h00;
    end
  end

  assign w_c1 = regs_q[ccsg_pkg::IDX_CTRL1_GATE];
  assign w_s1 = regs_q[ccsg_pkg::IDX_SYN1];
  assign w_s2 = regs_q[ccsg_pkg::IDX_SYN2];
  assign w_enc = regs_q[ccsg_pkg::IDX_ENC_BUS];
  assign w_sp = regs_q[ccsg_pkg::IDX_STREAMS];
  assign w_ct = regs_q[ccsg_pkg::IDX_CTRL];
  assign w_mb = regs_q[ccsg_pkg::IDX_MEMBR];
  assign w_lp = regs_q[ccsg_pkg::IDX_LOOP];
  assign w_tb = regs_q[ccsg_pkg::IDX_CTAB];

  // Synthesizer values sit in flops; a load strobe latches them into the loop
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_n <= 5'h00;
      mem_r <= 2'h0;
      mem_m <= 7'h00;
      pix_n <= 6'h00;
      pix_r <= 2'h0;
      pix_m <= 8'h00;
      pix_set0_n <= 6'h00;
      pix_set0_r <= 2'h0;
      pix_set0_m <= 8'h00;
      pix_set1_n <= 6'h00;
      pix_set1_r <= 2'h0;
      pix_set1_m <= 8'h00;
    end
    else if (clk_en)
    begin
      mem_n <= regs_q[ccsg_pkg::IDX_MEM_LO][4:0];
      mem_r <= regs_q[ccsg_pkg::IDX_MEM_LO][6:5];
      mem_m <= regs_q[ccsg_pkg::IDX_MEM_HI][6:0];
      pix_n <= regs_q[ccsg_pkg::IDX_PIX_LO][5:0];
      pix_r <= regs_q[ccsg_pkg::IDX_PIX_LO][7:6];
      pix_m <= regs_q[ccsg_pkg::IDX_PIX_HI];
      pix_set0_n <= regs_q[ccsg_pkg::IDX_SET0_LO][5:0];
      pix_set0_r <= regs_q[ccsg_pkg::IDX_SET0_LO][7:6];
      pix_set0_m <= regs_q[ccsg_pkg::IDX_SET0_HI];
      pix_set1_n <= regs_q[ccsg_pkg::IDX_SET1_LO][5:0];
      pix_set1_r <= regs_q[ccsg_pkg::IDX_SET1_LO][7:6];
      pix_set1_m <= regs_q[ccsg_pkg::IDX_SET1_HI];
    end
  end

  // Load requests are levels held by software; loop samples them
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_load <= 1'b0;
      pix_load <= 1'b0;
      synth_cnt_clear <= 1'b0;
      mem_loop_pd <= 1'b0;
      pix_loop_pd <= 1'b0;
      pads_suspend <= 1'b0;
    end
    else if (clk_en)
    begin
      mem_load <= w_s2[ccsg_pkg::SYN2_LOAD_MEM] | w_s2[ccsg_pkg::SYN2_LOAD_NOW];
      pix_load <= w_s2[ccsg_pkg::SYN2_LOAD_PIX] | w_s2[ccsg_pkg::SYN2_LOAD_NOW];
      synth_cnt_clear <= w_s1[ccsg_pkg::SYN1_CLR_CNT];
      pix_loop_pd <= w_s1[ccsg_pkg::SYN1_PIX_PD] | (w_lp[ccsg_pkg::LOOP_PIX_OFF_SUSP] & in_suspend);
      mem_loop_pd <= w_s1[ccsg_pkg::SYN1_MEM_PD] | (w_lp[ccsg_pkg::LOOP_MEM_OFF_SUSP] & in_suspend);
      pads_suspend <= w_lp[ccsg_pkg::LOOP_PADS_SUSP] & in_suspend;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_two_cycle_write <= 1'b0;
      conv_clock_double <= 1'b0;
      color_lookup_table_one_cycle_write <= 1'b0;
      mem_src_sel <= 2'h0;
      mem_div_sel <= 2'h0;
      pix_src_a_sel <= 2'h0;
      pix_div_a_sel <= 2'h0;
      pix_src_b_sel <= 2'h0;
      pix_div_b_sel <= 2'h0;
    end
    else if (clk_en)
    begin
      mem_two_cycle_write <= w_s2[ccsg_pkg::SYN2_TWO_CYC_WR];
      conv_clock_double <= regs_q[ccsg_pkg::IDX_CONV][ccsg_pkg::CONV_DOUBLE];
      color_lookup_table_one_cycle_write <= regs_q[ccsg_pkg::IDX_CONV][ccsg_pkg::CONV_ONE_CYC];
      mem_src_sel <= regs_q[ccsg_pkg::IDX_MEM_SEL][1:0];
      mem_div_sel <= regs_q[ccsg_pkg::IDX_MEM_SEL][3:2];
      pix_src_a_sel <= regs_q[ccsg_pkg::IDX_PIX_SEL][1:0];
      pix_div_a_sel <= regs_q[ccsg_pkg::IDX_PIX_SEL][3:2];
      pix_src_b_sel <= regs_q[ccsg_pkg::IDX_PIX_SEL][5:4];
      pix_div_b_sel <= regs_q[ccsg_pkg::IDX_PIX_SEL][7:6];
    end
  end

  // Run terms, combinational, then registered once
  always_comb
  begin
    g_enc = !stop3(w_enc[4:2], encoder_disabled, in_standby, in_suspend);
    g_lb = !stop3(w_enc[7:5], local_bus_disabled, in_standby, in_suspend);
    g_s1 = !stop3(w_sp[5:3], streams_disabled, in_standby, in_suspend);
    g_s2 = !stop3({w_sp[7:6], 1'b0}, 1'b0, in_standby, in_suspend);
    g_t1 = !(stop3({1'b0, w_c1[6:5]}, in_standby, in_suspend, 1'b0)
      | (w_ct[0] & ctrl1_disabled));
    g_v1 = !(stop3(w_c1[4:2], display_mode == ccsg_pkg::MODE_VIRT_OFF, in_standby, in_suspend)
      | (w_ct[0] & ctrl1_disabled));
    g_c2 = !stop3(w_ct[4:2], ctrl2_disabled, in_standby, in_standby);
    g_biu = !(w_ct[7] & in_suspend);
    g_ge = !(w_mb[0] & in_suspend);
    g_dm = !(w_mb[1] & in_suspend);
    g_bm = !(w_mb[2] & in_suspend);
    g_lm = !(w_mb[3] & in_suspend);
    g_dp = !(w_mb[4] & in_suspend);
    g_fp = !(w_mb[7] & in_suspend);
    g_mc = !(w_mb[ccsg_pkg::MEMBR_ENABLE] & in_suspend);
    g_k1 = !(w_tb[0] | stop3({w_tb[3:2], 1'b0}, 1'b0, in_standby, in_suspend));
    g_k2 = !(w_tb[4] | stop3(w_tb[7:5], ctrl2_disabled, in_standby, in_suspend));
  end

  // Registered enables feed latch-based gate cells that switch only while
  // the branch clock is low, so no shortened pulse can appear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      encoder_clk_en <= 1'b1;
      local_bus_clk_en <= 1'b1;
      streams_clk1_en <= 1'b1;
      streams_clk2_en <= 1'b1;
      ctrl1_true_clk_en <= 1'b1;
      ctrl1_virt_clk_en <= 1'b1;
      ctrl2_clk_en <= 1'b1;
      biu_sys_clk_en <= 1'b1;
    end
    else if (clk_en)
    begin
      encoder_clk_en <= g_enc;
      local_bus_clk_en <= g_lb;
      streams_clk1_en <= g_s1;
      streams_clk2_en <= g_s2;
      ctrl1_true_clk_en <= g_t1;
      ctrl1_virt_clk_en <= g_v1;
      ctrl2_clk_en <= g_c2;
      biu_sys_clk_en <= g_biu;
    end
  end

  // Memory clock branches; a stopped branch freezes its logic, so the
  // memory side must be idle before Suspend is entered
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ge_mclk_en <= 1'b1;
      dm_mclk_en <= 1'b1;
      biu_mclk_en <= 1'b1;
      lpb_mclk_en <= 1'b1;
      disp_mclk_en <= 1'b1;
      fp_mclk_en <= 1'b1;
      mclk_en <= 1'b1;
    end
    else if (clk_en)
    begin
      ge_mclk_en <= g_ge;
      dm_mclk_en <= g_dm;
      biu_mclk_en <= g_bm;
      lpb_mclk_en <= g_lm;
      disp_mclk_en <= g_dp;
      fp_mclk_en <= g_fp;
      mclk_en <= g_mc;
    end
  end

  // Color table power enables are levels, not clock gates
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctab1_on <= 1'b1;
      ctab2_on <= 1'b1;
    end
    else if (clk_en)
    begin
      ctab1_on <= g_k1;
      ctab2_on <= g_k2;
    end
  end
endmodule
`default_nettype wire

// >>> verification/ccsg_chk.sv
/*
  Checker for ccsg_top: gating enables and read data tied to their causes.
  Assumes it is bound to the top module, whose ports it sees.
*/
`timescale 1ns/1ps
`default_nettype none
module ccsg_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] seq_index,
  input wire logic seq_rd,
  input wire logic [7:0] seq_rdata,
  // Power state and unit status
  input wire logic in_standby,
  input wire logic in_suspend,
  input wire logic encoder_disabled,
  input wire logic local_bus_disabled,
  input wire logic ctrl2_disabled,
  // Outputs watched
  input wire logic pads_suspend,
  input wire logic encoder_clk_en,
  input wire logic local_bus_clk_en,
  input wire logic streams_clk2_en,
  input wire logic ctrl2_clk_en,
  input wire logic biu_sys_clk_en,
  input wire logic ge_mclk_en,
  input wire logic mclk_en
);
  // Past cycle was live; a frozen or reset cycle says nothing of the cause
  logic live_q;
  always_ff @(posedge clk) live_q <= rst_n & clk_en;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd_unmapped;
    clk_en && seq_rd && seq_index == 8'h30;
  endsequence
  property p_pads; live_q && pads_suspend |-> $past(in_suspend); endproperty
  property p_enc; live_q && !encoder_clk_en |-> $past(in_standby || in_suspend || encoder_disabled); endproperty
  property p_lbus; live_q && !local_bus_clk_en |-> $past(in_standby || in_suspend || local_bus_disabled);
  endproperty
  property p_str2; live_q && !streams_clk2_en |-> $past(in_standby || in_suspend); endproperty
  property p_ctrl2; live_q && !ctrl2_clk_en |-> $past(in_standby || ctrl2_disabled); endproperty
  property p_biu; live_q && !biu_sys_clk_en |-> $past(in_suspend); endproperty
  property p_mclk; live_q && !(mclk_en && ge_mclk_en) |-> $past(in_suspend); endproperty
  property p_unmapped; s_rd_unmapped |=> (seq_rdata == 8'h00) [*2]; endproperty
  a_pads: assert property (p_pads) else $error("pads in suspend setup outside suspend");
  a_enc: assert property (p_enc) else $error("encoder clock stopped without cause");
  a_lbus: assert property (p_lbus) else $error("local bus clock stopped without cause");
  a_str2: assert property (p_str2) else $error("streams branch 2 stopped without cause");
  a_ctrl2: assert property (p_ctrl2) else $error("controller 2 clock stopped without cause");
  a_biu: assert property (p_biu) else $error("bus interface clock stopped outside suspend");
  a_mclk: assert property (p_mclk) else $error("memory clock stopped outside suspend");
  a_unmapped: assert property (p_unmapped) else $error("unmapped index read nonzero");
endmodule
`default_nettype wire

// >>> verification/tb_clock_synth_and_gating.sv
/*
  Testbench for ccsg_top: lock, register fields, modes and branch gating.
  Assumes rtl/ccsg_pkg.sv and rtl/ccsg_top.sv are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_clock_synth_and_gating;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic seq_wr = 1'b0;
  logic seq_rd = 1'b0;
  logic in_standby = 1'b0;
  logic in_suspend = 1'b0;
  logic [4:0] dis = 5'h00;
  logic [1:0] display_mode = 2'h0;
  logic [7:0] seq_index = 8'h00;
  logic [7:0] seq_wdata = 8'h00;
  logic [7:0] seq_rdata, pix_m, pix_set0_m, pix_set1_m, g_vec, m_vec, d;
  logic [6:0] mem_m;
  logic [5:0] pix_n, pix_set0_n, pix_set1_n;
  logic [4:0] mem_n;
  logic [3:0] p_vec;
  logic [1:0] mem_r, mem_src_sel, mem_div_sel, pix_r, pix_set0_r, pix_set1_r;
  logic [1:0] pix_src_a_sel, pix_div_a_sel, pix_src_b_sel, pix_div_b_sel;
  logic mem_load, mem_loop_pd, pix_load, pix_loop_pd, synth_cnt_clear, mem_two_cycle_write;
  logic conv_clock_double, color_lookup_table_one_cycle_write, pads_suspend, encoder_clk_en, local_bus_clk_en;
  logic streams_clk1_en, streams_clk2_en, ctrl1_true_clk_en, ctrl1_virt_clk_en, ctrl2_clk_en;
  logic biu_sys_clk_en, ge_mclk_en, dm_mclk_en, biu_mclk_en, lpb_mclk_en, disp_mclk_en;
  logic fp_mclk_en, mclk_en, ctab1_on, ctab2_on;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  // Synth values first, gating setup from entry 12 on
  localparam logic [7:0] TI [20] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h22, 8'h23, 8'h24, 8'h25, 8'h14,
    8'h18, 8'h27, 8'h28, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h09, 8'h14};
  localparam logic [7:0] TV [20] = '{8'hff, 8'h85, 8'h9b, 8'hc4, 8'h7e, 8'h81, 8'h41, 8'h18, 8'h13,
    8'hc0, 8'hb6, 8'h1b, 8'hfc, 8'hf8, 8'h9d, 8'hbf, 8'h98, 8'hec, 8'h7c, 8'h00};
  assign g_vec = {encoder_clk_en, local_bus_clk_en, streams_clk1_en, streams_clk2_en,
    ctrl1_true_clk_en, ctrl1_virt_clk_en, ctrl2_clk_en, biu_sys_clk_en};
  assign m_vec = {ge_mclk_en, dm_mclk_en, biu_mclk_en, lpb_mclk_en, disp_mclk_en, fp_mclk_en, mclk_en,
    pads_suspend};
  assign p_vec = {ctab1_on, ctab2_on, pix_loop_pd, mem_loop_pd};
  ccsg_top u_ccsg_top (.clk, .rst_n, .clk_en, .seq_index, .seq_wr, .seq_rd, .seq_wdata, .seq_rdata,
    .in_standby, .in_suspend, .encoder_disabled(dis[0]), .local_bus_disabled(dis[1]),
    .streams_disabled(dis[2]), .ctrl1_disabled(dis[3]), .ctrl2_disabled(dis[4]), .display_mode,
    .mem_n, .mem_r, .mem_m, .mem_load, .mem_loop_pd, .mem_src_sel, .mem_div_sel, .pix_n, .pix_r,
    .pix_m, .pix_set0_n, .pix_set0_r, .pix_set0_m, .pix_set1_n, .pix_set1_r, .pix_set1_m, .pix_load,
    .pix_loop_pd, .pix_src_a_sel, .pix_div_a_sel, .pix_src_b_sel, .pix_div_b_sel, .synth_cnt_clear,
    .mem_two_cycle_write, .conv_clock_double, .color_lookup_table_one_cycle_write, .pads_suspend, .encoder_clk_en,
    .local_bus_clk_en, .streams_clk1_en, .streams_clk2_en, .ctrl1_true_clk_en, .ctrl1_virt_clk_en,
    .ctrl2_clk_en, .biu_sys_clk_en, .ge_mclk_en, .dm_mclk_en, .biu_mclk_en, .lpb_mclk_en,
    .disp_mclk_en, .fp_mclk_en, .mclk_en, .ctab1_on, .ctab2_on);
  always #12.5 clk = ~clk;
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    chk_reg(got, exp);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    @(negedge clk);
    seq_index = idx;
    seq_wdata = val;
    seq_wr = 1'b1;
    @(negedge clk);
    seq_wr = 1'b0;
  endtask
  // Read data lands one edge after the strobe and then stands
  task automatic rd(input logic [7:0] idx, output logic [7:0] val);
    @(negedge clk);
    seq_index = idx;
    seq_rd = 1'b1;
    @(negedge clk);
    seq_rd = 1'b0;
    @(negedge clk);
    val = seq_rdata;
  endtask
  task automatic t_lock();
    chk_pin({encoder_clk_en, mclk_en, ctab1_on, mem_load, pads_suspend, 3'h0}, 8'he0);
    wr(ccsg_pkg::IDX_SYN2, 8'h01);
    rd(ccsg_pkg::IDX_SYN2, d);
    chk_reg(d, 8'h00);
    chk_pin({7'h0, mem_load}, 8'h00);
    wr(ccsg_pkg::IDX_UNLOCK, 8'hf6);
    wr(ccsg_pkg::IDX_SYN2, 8'ha3);
    rd(ccsg_pkg::IDX_SYN2, d);
    chk_reg(d, 8'ha3);
    chk_pin({4'h0, mem_load, pix_load, mem_two_cycle_write, 1'b0}, 8'h0e);
    wr(ccsg_pkg::IDX_SYN2, 8'h20);
    repeat (2) @(negedge clk);
    chk_pin({4'h0, mem_load, pix_load, mem_two_cycle_write, 1'b0}, 8'h0c);
    wr(8'h30, 8'h5a);
    rd(8'h30, d);
    chk_reg(d, 8'h00);
    $display("lock test done");
  endtask
  task automatic t_synth();
    for (int i = 0; i < 12; i++) wr(TI[i], TV[i]);
    wr(ccsg_pkg::IDX_TEST_A, 8'h3c);
    @(negedge clk);
    clk_en = 1'b0;
    wr(ccsg_pkg::IDX_MEM_HI, 8'h7f);
    clk_en = 1'b1;
    repeat (2) @(negedge clk);
    chk_pin({1'b0, mem_r, mem_n}, 8'h7f);
    chk_pin({1'b0, mem_m}, 8'h05);
    chk_pin({pix_r, pix_n}, 8'h9b);
    chk_pin(pix_m, 8'hc4);
    chk_pin({pix_set0_r, pix_set0_n}, 8'h7e);
    chk_pin(pix_set0_m, 8'h81);
    chk_pin({pix_set1_r, pix_set1_n}, 8'h41);
    chk_pin(pix_set1_m, 8'h18);
    chk_pin({5'h0, pix_loop_pd, mem_loop_pd, synth_cnt_clear}, 8'h07);
    chk_pin({6'h0, conv_clock_double, color_lookup_table_one_cycle_write}, 8'h03);
    chk_pin({mem_div_sel, mem_src_sel, 4'h0}, 8'h60);
    chk_pin({pix_div_b_sel, pix_src_b_sel, pix_div_a_sel, pix_src_a_sel}, 8'h1b);
    rd(ccsg_pkg::IDX_TEST_A, d);
    chk_reg(d, 8'h3c);
    $display("synth test done");
  endtask
  task automatic t_case(input logic sb, sp, dd, input logic [1:0] md, input logic [7:0] eg, em,
    input logic [3:0] ep);
    @(negedge clk);
    in_standby = sb;
    in_suspend = sp;
    dis = {5{dd}};
    display_mode = md;
    repeat (2) @(negedge clk);
    chk_pin(g_vec, eg);
    chk_pin(m_vec, em);
    chk_pin({4'h0, p_vec}, {4'h0, ep});
    $display("gating case done");
  endtask
  task automatic t_rerst();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    wr(ccsg_pkg::IDX_SYN2, 8'h01);
    rd(ccsg_pkg::IDX_SYN2, d);
    chk_reg(d, 8'h00);
    $display("second reset test done");
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // A hang would otherwise stall the run; about a hundred cycles are expected
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_lock();
    t_synth();
    for (int i = 12; i < 20; i++) wr(TI[i], TV[i]);
    t_case(1'b0, 1'b0, 1'b0, 2'h0, 8'hff, 8'hfe, 4'hc);
    t_case(1'b1, 1'b0, 1'b0, 2'h0, 8'h01, 8'hfe, 4'h0);
    t_case(1'b0, 1'b1, 1'b0, 2'h0, 8'h02, 8'h01, 4'h3);
    t_case(1'b0, 1'b0, 1'b1, 2'h3, 8'h11, 8'hfe, 4'h8);
    t_case(1'b0, 1'b0, 1'b0, 2'h3, 8'hfb, 8'hfe, 4'hc);
    t_rerst();
    tally_and_finish();
  end
endmodule
bind ccsg_top ccsg_chk u_ccsg_chk (.clk, .rst_n, .clk_en, .seq_index, .seq_rd, .seq_rdata, .in_standby,
  .in_suspend, .encoder_disabled, .local_bus_disabled, .ctrl2_disabled, .pads_suspend, .encoder_clk_en,
  .local_bus_clk_en, .streams_clk2_en, .ctrl2_clk_en, .biu_sys_clk_en, .ge_mclk_en, .mclk_en);
`default_nettype wire
